//--- rtl/sac_adc_regs.svh
`ifndef SAC_ADC_REGS_SVH
`define SAC_ADC_REGS_SVH
// ==========================================
// register byte offsets
`define SAC_OFS_STATUS_CONTROL 8'h00
`define SAC_OFS_RESULT_HIGH 8'h04
`define SAC_OFS_RESULT_LOW 8'h08
`define SAC_OFS_CLOCK_CONFIG 8'h0C
// ==========================================
// status/control fields
`define SAC_BIT_COMPLETE 7
`define SAC_BIT_IRQ_EN 6
`define SAC_BIT_CONT_EN 5
`define SAC_CHAN_MSB 4
`define SAC_CHAN_LSB 0
`define SAC_RST_STATUS_CONTROL 8'h1F
// ==========================================
// clock configuration fields
`define SAC_DIV_MSB 7
`define SAC_DIV_LSB 5
`define SAC_BIT_CLK_SRC 4
`define SAC_BIT_FMT_HI 3
`define SAC_BIT_FMT_LO 2
`define SAC_RST_CLOCK_CONFIG 8'h00
// ==========================================
// channel codes
`define SAC_CHAN_COUNT 7
`define SAC_CHAN_POWER_OFF 5'h1F
// ==========================================
// conversion timing in converter clock ticks, and the first trial code
`define SAC_SAMPLE_TICKS 4'h5
`define SAC_LAST_TICK 4'hF
`define SAC_FIRST_TRIAL 10'h200
`endif

//--- rtl/sac_adc_pkg.sv
package sac_adc_pkg;
  // ==========================================
  // result format choices
  typedef enum logic [1:0] {
    SAC_FMT_LEFT = 2'h0,
    SAC_FMT_RIGHT = 2'h1,
    SAC_FMT_SIGNED = 2'h2,
    SAC_FMT_TRUNC = 2'h3
  } sac_fmt_type;
  // ==========================================
  // converter sequencer states
  typedef enum logic [1:0] {
    SAC_IDLE,
    SAC_ARM,
    SAC_CONV
  } sac_state_type;
  // ==========================================
  // formatted result byte pair
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } sac_result_type;
endpackage

//--- rtl/sac_clk_div.sv
`include "sac_adc_regs.svh"
module sac_clk_div (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // source selection
  input wire logic oscTick,
  input wire logic srcSel,
  input wire logic [2:0] divSel,
  // converter clock enable
  output logic convTick
);
  import sac_adc_pkg::*;
  logic [3:0] cnt_r;
  logic [3:0] lim;
  logic srcTick;
  // codes above four saturate at divide by sixteen
  assign lim = (divSel > 3'h4) ? 4'hF :
    4'((5'h01 << divSel) - 5'h01);
  assign srcTick = srcSel ? oscTick : 1'b1;
  // ==========================================
  // free running divider
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= 4'h0;
      convTick <= 1'b0;
    end else begin
      convTick <= 1'b0;
      if (srcTick) begin
        if (cnt_r >= lim) begin
          cnt_r <= 4'h0;
          convTick <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 4'h1;
        end
      end
    end
  end
endmodule // sac_clk_div

//--- rtl/sac_result_fmt.sv
module sac_result_fmt (
  // raw code and format
  input wire logic [9:0] code,
  input sac_adc_pkg::sac_fmt_type fmt,
  // formatted bytes
  output sac_adc_pkg::sac_result_type result
);
  import sac_adc_pkg::*;
  // ==========================================
  // four justifications
  always_comb begin
    result = '0;
    case (fmt)
      SAC_FMT_LEFT: begin
        result.high = code[9:2];
        result.low = {code[1:0], 6'h00};
      end
      SAC_FMT_RIGHT: begin
        result.high = {6'h00, code[9:8]};
        result.low = code[7:0];
      end
      SAC_FMT_SIGNED: begin
        result.high = {~code[9], code[8:2]};
        result.low = {code[1:0], 6'h00};
      end
      default: begin
        result.high = 8'h00;
        result.low = code[9:2];
      end
    endcase
  end
endmodule // sac_result_fmt

//--- rtl/sac_adc_top.sv
`include "sac_adc_regs.svh"
module sac_adc_top (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // converter clock source and power modes
  input wire logic oscTick,
  input wire logic waitMode,
  input wire logic stopMode,
  // analog front end
  input wire logic cmpHigh,
  output logic [9:0] dacCode,
  output logic sampleEn,
  output logic [4:0] muxSel,
  output logic analogPowerDown,
  // shared port pins
  input wire logic [6:0] portData,
  input wire logic [6:0] portDir,
  input wire logic [6:0] pinLevel,
  output logic [6:0] pinOut,
  output logic [6:0] pinOe,
  output logic [6:0] portReadData,
  // processor interrupt
  output logic irqReq
);
  import sac_adc_pkg::*;
  // ==========================================
  // declarations
  logic [7:0] statusCtl_r;
  logic [7:0] clockCfg_r;
  logic [7:0] resultHigh_r;
  logic [7:0] resultLow_r;
  logic lowFrozen_r;
  logic runReq_r;
  logic stopSeen_r;
  sac_state_type state_r;
  logic [3:0] tick_r;
  logic [9:0] trial_r;
  logic [9:0] trial_nxt;
  logic [9:0] finalCode;
  logic [3:0] bitIdx;
  logic [9:0] bitMask;
  logic [9:0] keptTrial;
  logic convTick;
  logic convDone;
  sac_fmt_type fmt;
  sac_result_type fmtResult;
  logic accessEnd;
  logic wrEnd;
  logic rdEnd;
  logic statusWr;
  logic clockWr;
  logic highRd;
  logic lowRd;
  logic resultRd;
  logic startReq;
  logic powerOff;
  logic irqEn;
  logic contEn;
  logic interlocked;
  logic [31:0] rdMux;
  logic mapped;
  // ==========================================
  // apb decode
  assign accessEnd = psel && penable && pready;
  assign wrEnd = accessEnd && pwrite;
  assign rdEnd = accessEnd && !pwrite;
  assign statusWr = wrEnd && (paddr == `SAC_OFS_STATUS_CONTROL);
  assign clockWr = wrEnd && (paddr == `SAC_OFS_CLOCK_CONFIG);
  assign highRd = rdEnd && (paddr == `SAC_OFS_RESULT_HIGH);
  assign lowRd = rdEnd && (paddr == `SAC_OFS_RESULT_LOW);
  assign resultRd = highRd || lowRd;
  always_comb begin
    rdMux = 32'h0000_0000;
    mapped = 1'b1;
    if (paddr == `SAC_OFS_STATUS_CONTROL) begin
      rdMux = {24'h00_0000, statusCtl_r};
    end else if (paddr == `SAC_OFS_RESULT_HIGH) begin
      rdMux = {24'h00_0000, resultHigh_r};
    end else if (paddr == `SAC_OFS_RESULT_LOW) begin
      rdMux = {24'h00_0000, resultLow_r};
    end else if (paddr == `SAC_OFS_CLOCK_CONFIG) begin
      rdMux = {24'h00_0000, clockCfg_r};
    end else begin
      mapped = 1'b0;
    end
  end
  // ==========================================
  // apb handshake: one wait state per access
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready) begin
        prdata <= pwrite ? 32'h0000_0000 : rdMux;
        pslverr <= !mapped;
      end else begin
        prdata <= 32'h0000_0000;
        pslverr <= 1'b0;
      end
    end
  end
  // ==========================================
  // control fields
  assign powerOff = statusCtl_r[`SAC_CHAN_MSB:`SAC_CHAN_LSB] ==
    `SAC_CHAN_POWER_OFF;
  assign irqEn = statusCtl_r[`SAC_BIT_IRQ_EN];
  assign contEn = statusCtl_r[`SAC_BIT_CONT_EN];
  assign fmt = sac_fmt_type'({clockCfg_r[`SAC_BIT_FMT_HI],
    clockCfg_r[`SAC_BIT_FMT_LO]});
  assign interlocked = fmt != SAC_FMT_TRUNC;
  assign startReq = statusWr &&
    (pwdata[`SAC_CHAN_MSB:`SAC_CHAN_LSB] != `SAC_CHAN_POWER_OFF);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clockCfg_r <= `SAC_RST_CLOCK_CONFIG;
    end else if (clockWr) begin
      clockCfg_r <= pwdata[7:0];
    end
  end
  // ==========================================
  // status/control with sticky complete flag
  // set beats clear so a finish in the clearing cycle is kept
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      statusCtl_r <= `SAC_RST_STATUS_CONTROL;
    end else begin
      if (statusWr) begin
        statusCtl_r[6:0] <= pwdata[6:0];
        // writable only as the service select with irq on
        statusCtl_r[`SAC_BIT_COMPLETE] <=
          pwdata[`SAC_BIT_IRQ_EN] && pwdata[`SAC_BIT_COMPLETE];
      end else if (resultRd && !irqEn) begin
        statusCtl_r[`SAC_BIT_COMPLETE] <= 1'b0;
      end
      if (convDone && !irqEn) begin
        statusCtl_r[`SAC_BIT_COMPLETE] <= 1'b1;
      end
    end
  end
  // ==========================================
  // run request survives stop mode
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      runReq_r <= 1'b0;
    end else if (statusWr) begin
      runReq_r <= startReq;
    end else if (convDone && !contEn) begin
      runReq_r <= 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stopSeen_r <= 1'b0;
    end else begin
      stopSeen_r <= stopMode;
    end
  end
  // ==========================================
  // converter clock
  sac_clk_div uDiv (
    .clk(clk),
    .rst_n(rst_n),
    .oscTick(oscTick),
    .srcSel(clockCfg_r[`SAC_BIT_CLK_SRC]),
    .divSel(clockCfg_r[`SAC_DIV_MSB:`SAC_DIV_LSB]),
    .convTick(convTick)
  );
  // ==========================================
  // successive approximation sequencer
  assign bitIdx = `SAC_LAST_TICK - tick_r;
  assign bitMask = 10'(10'h001 << bitIdx);
  // comparator low clears the bit under trial
  assign keptTrial = cmpHigh ? trial_r : (trial_r & ~bitMask);
  assign finalCode = keptTrial;
  assign convDone = (state_r == SAC_CONV) && convTick &&
    (tick_r == `SAC_LAST_TICK) && !stopMode && !statusWr;
  // the next trial feeds the dac too, so the comparator always
  // judges the code under trial and not the one before it
  always_comb begin
    trial_nxt = trial_r;
    if ((state_r == SAC_CONV) && convTick && !stopMode && !statusWr) begin
      if (tick_r == `SAC_SAMPLE_TICKS) begin
        trial_nxt = `SAC_FIRST_TRIAL;
      end else if (tick_r > `SAC_SAMPLE_TICKS) begin
        trial_nxt = keptTrial | (bitMask >> 1);
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      trial_r <= 10'h000;
    end else begin
      trial_r <= trial_nxt;
    end
  end
  // wait mode is not looked at: conversions run on through it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= SAC_IDLE;
      tick_r <= 4'h0;
    end else if (stopMode) begin
      state_r <= SAC_IDLE;
      tick_r <= 4'h0;
    end else if (statusWr) begin
      state_r <= startReq ? SAC_ARM : SAC_IDLE;
      tick_r <= 4'h0;
    end else begin
      case (state_r)
        SAC_IDLE: begin
          if (stopSeen_r && runReq_r) begin
            state_r <= SAC_ARM;
          end
        end
        SAC_ARM: begin
          // partial tick before this is the extra cycle
          if (convTick) begin
            state_r <= SAC_CONV;
            tick_r <= 4'h0;
          end
        end
        SAC_CONV: begin
          if (convTick) begin
            tick_r <= tick_r + 4'h1;
            if (tick_r == `SAC_LAST_TICK) begin
              state_r <= contEn ? SAC_CONV : SAC_IDLE;
              tick_r <= 4'h0;
            end
          end
        end
        default: begin
          state_r <= SAC_IDLE;
        end
      endcase
    end
  end
  // ==========================================
  // analog front end drive
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dacCode <= 10'h000;
      sampleEn <= 1'b0;
      muxSel <= `SAC_CHAN_POWER_OFF;
      analogPowerDown <= 1'b1;
    end else begin
      dacCode <= trial_nxt;
      // stop cuts sampling at once, not one cycle later
      sampleEn <= !stopMode && (state_r == SAC_CONV) &&
        (tick_r <= `SAC_SAMPLE_TICKS);
      muxSel <= statusCtl_r[`SAC_CHAN_MSB:`SAC_CHAN_LSB];
      analogPowerDown <= powerOff || stopMode;
    end
  end
  // ==========================================
  // result registers and read interlock
  sac_result_fmt uFmt (
    .code(finalCode),
    .fmt(fmt),
    .result(fmtResult)
  );
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      resultHigh_r <= 8'h00;
      resultLow_r <= 8'h00;
    end else if (convDone && !(lowFrozen_r && interlocked)) begin
      resultHigh_r <= fmtResult.high;
      resultLow_r <= fmtResult.low;
    end
  end
  // a low read always releases, even alongside a new result
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lowFrozen_r <= 1'b0;
    end else if (lowRd) begin
      lowFrozen_r <= 1'b0;
    end else if (highRd && interlocked) begin
      lowFrozen_r <= 1'b1;
    end
  end
  // ==========================================
  // interrupt request
  // stays high through wait mode so it can wake the core
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irqReq <= 1'b0;
    end else if (convDone && irqEn &&
      !statusCtl_r[`SAC_BIT_COMPLETE]) begin
      irqReq <= 1'b1;
    end else if (statusWr || resultRd || !irqEn) begin
      irqReq <= 1'b0;
    end
  end
  // ==========================================
  // shared pin override, one slice per channel
  genvar gi;
  generate
    for (gi = 0; gi < `SAC_CHAN_COUNT; gi++) begin : gPin
      logic chanSel;
      assign chanSel = !powerOff &&
        (statusCtl_r[`SAC_CHAN_MSB:`SAC_CHAN_LSB] == 5'(gi));
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          pinOut[gi] <= 1'b0;
          pinOe[gi] <= 1'b0;
          portReadData[gi] <= 1'b0;
        end else begin
          pinOut[gi] <= portData[gi];
          pinOe[gi] <= chanSel ? 1'b0 : portDir[gi];
          portReadData[gi] <= chanSel ? 1'b0 : pinLevel[gi];
        end
      end
    end
  endgenerate
endmodule // sac_adc_top

//--- verif/sac_analog_model.sv
module sac_analog_model (
  // converter side
  input wire logic clk,
  input wire logic [9:0] dacCode,
  input wire logic sampleEn,
  input wire logic analogPowerDown,
  input wire logic [10:0] anaLevel,
  output logic cmpHigh,
  // pin side
  input wire logic [6:0] pinOut,
  input wire logic [6:0] pinOe,
  input wire logic [6:0] extPins,
  output logic [6:0] pinLevel
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [10:0] held_r = 11'h000;
  logic junk_r = 1'b0;
  // input tracked while sampling and held after, as the capacitor array would
  always @(posedge clk) begin
    if (sampleEn) begin
      held_r <= anaLevel;
    end
    junk_r <= ~junk_r;
  end
  // powered down gives no trustworthy answer, so it toggles
  assign cmpHigh = analogPowerDown ? junk_r :
    held_r >= {1'b0, dacCode};
  assign pinLevel = (pinOe & pinOut) | (~pinOe & extPins);
endmodule // sac_analog_model

//--- verif/sac_adc_monitor.sv
`include "sac_adc_regs.svh"
module sac_adc_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // converter and pins
  input wire logic stopMode,
  input wire logic sampleEn,
  input wire logic [4:0] muxSel,
  input wire logic analogPowerDown,
  input wire logic [6:0] portDir,
  input wire logic [6:0] pinLevel,
  input wire logic [6:0] pinOe,
  input wire logic [6:0] portReadData,
  input wire logic irqReq
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========
  // helpers
  logic [6:0] selMask;
  logic acc, wr0, clrEv, started_r;
  assign acc = psel && penable && pready;
  assign wr0 = acc && pwrite && paddr == `SAC_OFS_STATUS_CONTROL;
  assign clrEv = wr0 || (acc && !pwrite && (paddr ==
    `SAC_OFS_RESULT_HIGH || paddr == `SAC_OFS_RESULT_LOW));
  assign selMask = (muxSel < 5'h07) ? 7'h01 << muxSel : 7'h00;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      started_r <= 1'b0;
    end else if (wr0) begin
      started_r <= 1'b1;
    end
  end
  // ==========
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_quiet15; !irqReq [*8] ##1 !irqReq [*7]; endsequence
  sequence s_stop2; stopMode ##1 stopMode; endsequence
  property p_ready; pready |=> !pready; endproperty
  property p_err; pslverr |-> pready; endproperty
  property p_oe; $past(rst_n) |-> pinOe == ($past(portDir) & ~selMask);
  endproperty
  property p_rd;
    $past(rst_n) |-> portReadData == ($past(pinLevel) & ~selMask);
  endproperty
  property p_off; muxSel == `SAC_CHAN_POWER_OFF |-> analogPowerDown;
  endproperty
  property p_stop; s_stop2 |-> analogPowerDown && !sampleEn; endproperty
  property p_idle; !started_r |-> !irqReq && !sampleEn; endproperty
  property p_clear; clrEv |=> !irqReq; endproperty
  property p_min; wr0 |=> s_quiet15; endproperty
  a_ready: assert property (p_ready)
    else $error("ready held past one cycle");
  a_err: assert property (p_err)
    else $error("error without ready");
  a_oe: assert property (p_oe)
    else $error("pin enable wrong");
  a_rd: assert property (p_rd)
    else $error("port read wrong");
  a_off: assert property (p_off)
    else $error("power-off code left converter on");
  a_stop: assert property (p_stop)
    else $error("converter active in stop");
  a_idle: assert property (p_idle)
    else $error("activity before first start");
  a_clear: assert property (p_clear)
    else $error("request not withdrawn");
  a_min: assert property (p_min)
    else $error("conversion too short");
endmodule // sac_adc_monitor
bind sac_adc_top sac_adc_monitor u_mon (.clk, .rst_n, .psel, .penable,
  .pwrite, .paddr, .pready, .pslverr, .stopMode, .sampleEn, .muxSel,
  .analogPowerDown, .portDir, .pinLevel, .pinOe, .portReadData, .irqReq);

//--- verif/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========
  // signals
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, oscTick = 1'b0, waitMode = 1'b0, stopMode = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [6:0] portData = 7'h00, portDir = 7'h00, extPins = 7'h00;
  logic [10:0] anaLevel = 11'h000;
  logic [1:0] oscCnt = 2'h0;
  logic [31:0] prdata;
  logic pready, pslverr, cmpHigh, sampleEn, analogPowerDown, irqReq, rde;
  logic [9:0] dacCode;
  logic [4:0] muxSel;
  logic [6:0] pinLevel, pinOut, pinOe, portReadData;
  logic [7:0] rdq;
  int n_errors = 0, n_compared = 0, n;
  logic [7:0] tCfg [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h00, 8'h04};
  logic [10:0] tLvl [6] = '{11'h2B5, 11'h2B5, 11'h2B5, 11'h2B5, 11'h7FF,
    11'h000};
  logic [7:0] tHi [6] = '{8'hAD, 8'h02, 8'h2D, 8'h00, 8'hFF, 8'h00};
  logic [7:0] tLo [6] = '{8'h40, 8'hB5, 8'h40, 8'hAD, 8'hC0, 8'h00};
  sac_adc_top uut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .oscTick, .waitMode, .stopMode, .cmpHigh,
    .dacCode, .sampleEn, .muxSel, .analogPowerDown, .portData, .portDir,
    .pinLevel, .pinOut, .pinOe, .portReadData, .irqReq);
  sac_analog_model u_ana (.clk, .dacCode, .sampleEn, .analogPowerDown,
    .anaLevel, .cmpHigh, .pinOut, .pinOe, .extPins, .pinLevel);
  initial begin
    forever #2.5 clk = ~clk;
  end
  // oscillator edge every fourth bus cycle
  always @(posedge clk) begin
    oscCnt <= oscCnt + 2'h1;
    oscTick <= (oscCnt == 2'h3);
  end
  // ==========
  // tasks
  task automatic end_sim;
    $display("TB: %0d compared, %0d mismatches", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] s, input logic [15:0] x);
    n_compared++;
    if (s !== x) begin
      n_errors++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, s, x);
    end
  endtask
  task automatic flag(input logic s, input logic x);
    chk({15'h0, s}, {15'h0, x});
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [7:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    // pready and prdata are read as sampled at the rising edge
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rdq = prdata[7:0];
    rde = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_errors++;
      end_sim();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    apb(1'b0, a, 8'h00);
    chk({8'h00, rdq}, {8'h00, x});
  endtask
  task automatic wirq(output int c);
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (irqReq !== 1'b1 && c < 1200);
    // the request rose at the edge before the one that saw it
    c--;
    if (irqReq !== 1'b1) begin
      n_errors++;
      end_sim();
    end
  endtask
  // start on channel two with the request enabled, time it
  task automatic conv(input logic [7:0] c, input logic [10:0] l,
    input int lo, input int hi);
    apb(1'b1, 8'h0C, c);
    anaLevel <= l;
    apb(1'b1, 8'h00, 8'h42);
    wirq(n);
    flag(n >= lo && n <= hi, 1'b1);
  endtask
  // ==========
  // tests
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h00, 8'h1F);
    rd(8'h0C, 8'h00);
    flag(irqReq, 1'b0);
    apb(1'b0, 8'h10, 8'h00);
    flag(rde, 1'b1);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      conv(tCfg[i], tLvl[i], 16, 17);
      rd(8'h04, tHi[i]);
      rd(8'h08, tLo[i]);
      flag(irqReq, 1'b0);
    end
    apb(1'b1, 8'h00, 8'hC2);
    repeat (40) @(posedge clk);
    #1;
    flag(irqReq, 1'b0);
    $display("test formats done");
    conv(8'h00, 11'h2B5, 16, 17);
    rd(8'h04, 8'hAD);
    anaLevel <= 11'h0FF;
    apb(1'b1, 8'h00, 8'h42);
    repeat (40) @(posedge clk);
    rd(8'h08, 8'h40);
    conv(8'h00, 11'h0FF, 16, 17);
    rd(8'h04, 8'h3F);
    conv(8'h0C, 11'h2B5, 16, 17);
    rd(8'h04, 8'h00);
    conv(8'h0C, 11'h0FF, 16, 17);
    rd(8'h08, 8'h3F);
    anaLevel <= 11'h2B5;
    apb(1'b1, 8'h00, 8'h42);
    repeat (5) @(posedge clk);
    anaLevel <= 11'h0FF;
    apb(1'b1, 8'h00, 8'h42);
    wirq(n);
    flag(n >= 16 && n <= 17, 1'b1);
    rd(8'h08, 8'h3F);
    waitMode <= 1'b1;
    conv(8'h1C, 11'h2B5, 64, 68);
    conv(8'h2C, 11'h2B5, 32, 34);
    waitMode <= 1'b0;
    rd(8'h08, 8'hAD);
    $display("test timing done");
    apb(1'b1, 8'h0C, 8'h04);
    apb(1'b1, 8'h00, 8'h22);
    repeat (18) @(posedge clk);
    rd(8'h00, 8'hA2);
    anaLevel <= 11'h0FF;
    repeat (40) @(posedge clk);
    rd(8'h00, 8'hA2);
    rd(8'h08, 8'hFF);
    apb(1'b1, 8'h00, 8'h02);
    repeat (20) @(posedge clk);
    n = 0;
    repeat (40) begin
      @(posedge clk);
      #1;
      if (sampleEn !== 1'b0) n++;
    end
    flag(n == 0, 1'b1);
    $display("test continuous done");
    apb(1'b1, 8'h0C, 8'h00);
    anaLevel <= 11'h2B5;
    apb(1'b1, 8'h00, 8'h42);
    repeat (5) @(posedge clk);
    stopMode <= 1'b1;
    repeat (30) @(posedge clk);
    stopMode <= 1'b0;
    #1;
    flag(irqReq, 1'b0);
    wirq(n);
    rd(8'h04, 8'hAD);
    rd(8'h08, 8'h40);
    portDir <= 7'h7F;
    portData <= 7'h55;
    extPins <= 7'h7F;
    apb(1'b1, 8'h00, 8'h03);
    repeat (3) @(posedge clk);
    #1;
    chk({9'h0, pinOe}, 16'h0077);
    chk({9'h0, pinOut}, 16'h0055);
    chk({9'h0, portReadData}, 16'h0055);
    apb(1'b1, 8'h00, 8'h1F);
    repeat (2) @(posedge clk);
    #1;
    flag(analogPowerDown, 1'b1);
    $display("test pins done");
    end_sim();
  end
endmodule // tb_top
